// File: rtl/rtc_i2c_register_access.v
// serial target interface: byte writes and sequential reads of the register array
// assumes scl and sda pins arrive unsynchronised; ref_clk far faster than scl
// Operation
// - device acknowledges id, address and data byte of a write; the data byte only while the write queue has room.
// - after a write's data byte the interface stays busy in a wait state until stop returns it idle or start begins a new transfer.
// - device acknowledges all three instruction bytes of a read.
// - device keeps sending bytes while the controller acknowledges each one.
// - pointer loads from address byte and advances per sent byte.
// - pointer past 13h wraps to 00h, data continues.
// - upper seven id bits must match identifier; low bit selects direction.
// - pointer clears to zero at reset.
// - every byte moves most significant bit first.
`timescale 1ns/1ps
`include "rtc_i2c_consts.vh"

module sync_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire do_wr;
  wire do_rd;

  // honest flags from the occupancy count
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_ff];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // storage has no reset, pointers do
  always @(posedge ref_clk)
  begin
    if (do_wr)
      mem[wr_ptr_ff] <= in_data;
    if (!rst_n)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      if (do_rd)
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      if (do_wr && !do_rd)
        count_ff <= count_ff + 1'b1;
      else if (do_rd && !do_wr)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule

module rtc_i2c_register_access #(
  parameter WORDS = `ARRAY_WORDS
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // serial pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // stream of written bytes with their register address
  output wire wr_valid,
  input wire wr_ready,
  output wire [7:0] wr_addr,
  output wire [7:0] wr_data,
  // status
  output wire busy,
  output wire [7:0] pointer
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ID = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_SEND = 3'h4;
  localparam ST_MACK = 3'h5;
  localparam ST_WAIT = 3'h6;

  reg scl_m_ff, scl_s_ff, scl_d_ff;
  reg sda_m_ff, sda_s_ff, sda_d_ff;
  reg [2:0] state_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] ptr_ff;
  reg ack_phase_ff;
  reg byte_done_ff;
  reg ack_ok_ff;
  reg rw_ff;
  reg drive_low_ff;
  reg [7:0] mem_ff [0:WORDS-1];
  wire scl_rise, scl_fall, start_det, stop_det;
  wire [7:0] ptr_inc;
  wire fifo_in_ready;
  reg fifo_push_ff;
  reg [15:0] fifo_word_ff;
  wire [15:0] fifo_out;

  // two-flop synchronisers plus a delay stage; logic uses the second and third stages
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  assign scl_rise = scl_s_ff && !scl_d_ff;
  assign scl_fall = !scl_s_ff && scl_d_ff;
  assign start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
  assign stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;
  // wrap past the top of the array
  assign ptr_inc = (ptr_ff == `ARRAY_TOP) ? `PTR_RESET : ptr_ff + 8'h01;

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_ff;
  assign busy = (state_ff != ST_IDLE);
  assign pointer = ptr_ff;

  // byte engine; samples on scl rise, changes sda on scl fall
  always @(posedge ref_clk)
  begin
    fifo_push_ff <= 1'b0;
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= `BIT_FIRST;
      shift_ff <= 8'h00;
      ptr_ff <= `PTR_RESET;
      ack_phase_ff <= 1'b0;
      byte_done_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      rw_ff <= 1'b0;
      drive_low_ff <= 1'b0;
      fifo_word_ff <= 16'h0000;
    end
    else if (start_det)
    begin
      // repeated start also lands here, pointer kept for the read
      state_ff <= ST_ID;
      byte_done_ff <= 1'b0;
      bit_cnt_ff <= `BIT_FIRST;
      ack_phase_ff <= 1'b0;
      drive_low_ff <= 1'b0;
    end
    else if (stop_det)
    begin
      state_ff <= ST_IDLE;
      drive_low_ff <= 1'b0;
    end
    else if (state_ff == ST_ID || state_ff == ST_ADDR || state_ff == ST_DATA)
    begin
      if (!ack_phase_ff && scl_rise)
      begin
        shift_ff <= {shift_ff[6:0], sda_s_ff};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        // the wrapping count reads zero both before and after a byte, so mark a full one
        byte_done_ff <= (bit_cnt_ff == `BIT_LAST);
      end
      else if (!ack_phase_ff && scl_fall && byte_done_ff)
      begin
        // eight bits in: decide acknowledge
        ack_phase_ff <= 1'b1;
        byte_done_ff <= 1'b0;
        if (state_ff == ST_ID)
        begin
          ack_ok_ff <= (shift_ff[7:1] == `DEV_ID);
          drive_low_ff <= (shift_ff[7:1] == `DEV_ID);
          rw_ff <= shift_ff[0];
        end
        else if (state_ff == ST_DATA)
        begin
          // a full write queue refuses the byte with no acknowledge
          ack_ok_ff <= fifo_in_ready;
          drive_low_ff <= fifo_in_ready;
          if (fifo_in_ready)
          begin
            fifo_push_ff <= 1'b1;
            fifo_word_ff <= {ptr_ff, shift_ff};
          end
        end
        else
        begin
          ack_ok_ff <= 1'b1;
          drive_low_ff <= 1'b1;
          ptr_ff <= shift_ff;
        end
      end
      else if (ack_phase_ff && scl_fall)
      begin
        ack_phase_ff <= 1'b0;
        drive_low_ff <= 1'b0;
        if (!ack_ok_ff)
          state_ff <= ST_WAIT;
        else if (state_ff == ST_ID && rw_ff)
        begin
          state_ff <= ST_SEND;
          shift_ff <= mem_ff[ptr_ff[4:0]];
          drive_low_ff <= !mem_ff[ptr_ff[4:0]][7];
          bit_cnt_ff <= `BIT_FIRST;
        end
        else if (state_ff == ST_ID)
          state_ff <= ST_ADDR;
        else if (state_ff == ST_ADDR)
          state_ff <= ST_DATA;
        else
          state_ff <= ST_WAIT; // one data byte per write
      end
    end
    else if (state_ff == ST_SEND && scl_fall)
    begin
      if (bit_cnt_ff == `BIT_LAST)
      begin
        // release for the controller's acknowledge
        drive_low_ff <= 1'b0;
        state_ff <= ST_MACK;
        ptr_ff <= ptr_inc;
      end
      else
      begin
        drive_low_ff <= !shift_ff[6];
        shift_ff <= {shift_ff[6:0], 1'b0};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
    else if (state_ff == ST_MACK && scl_rise)
    begin
      // low means acknowledge: send another byte, else stand by for stop
      ack_ok_ff <= !sda_s_ff;
    end
    else if (state_ff == ST_MACK && scl_fall)
    begin
      if (ack_ok_ff)
      begin
        state_ff <= ST_SEND;
        shift_ff <= mem_ff[ptr_ff[4:0]];
        drive_low_ff <= !mem_ff[ptr_ff[4:0]][7];
        bit_cnt_ff <= `BIT_FIRST;
      end
      else
        state_ff <= ST_WAIT;
    end
  end

  // write queue decouples the serial side from the array update
  sync_fifo #(
    .WIDTH(16),
    .DEPTH(`FIFO_DEPTH),
    .AW(4)
  ) u_wr_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(fifo_push_ff),
    .in_ready(fifo_in_ready),
    .in_data(fifo_word_ff),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  assign wr_addr = fifo_out[15:8];
  assign wr_data = fifo_out[7:0];

  // array updated as the user side drains each written byte
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi = gi + 1)
    begin : g_reg
      always @(posedge ref_clk)
      begin
        if (!rst_n)
          mem_ff[gi] <= 8'h00;
        else if (wr_valid && wr_ready && fifo_out[15:8] == gi)
          mem_ff[gi] <= fifo_out[7:0];
      end
    end
  endgenerate
endmodule

// File: pkg/rtc_i2c_consts.vh
// constants for the serial register access target
// assumes inclusion by bare name from rtl files
`ifndef RTC_I2C_CONSTS_VH
`define RTC_I2C_CONSTS_VH
// device identifier, value is arbitrary
`define DEV_ID 7'h2A
`define ARRAY_TOP 8'h13
`define ARRAY_WORDS 20
`define PTR_RESET 8'h00
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define FIFO_DEPTH 16
`endif

// File: verification/rtc_i2c_register_access_sva.sv
// checker for the serial register target, sees top module ports only
// assumes bind onto the top module; one clock domain
`timescale 1ns/1ps
module rtc_i2c_chk (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // serial pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  // write stream and status
  input wire wr_valid,
  input wire wr_ready,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire busy,
  input wire [7:0] pointer
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // open drain: never drives high
  pin_low_a: assert property (sda_out == 1'b0) else $error("sda driven high");
  reset_state_a: assert property (disable iff (1'b0) !rst_n |=> !sda_oe && !busy && pointer == 8'h00 && !wr_valid)
    else $error("reset state wrong");
  // sda may only move while scl is low, else it reads as start or stop
  oe_edge_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
  oe_busy_a: assert property (sda_oe |-> busy) else $error("sda pulled while idle");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
    else $error("write entry not held");
  start_seen_a: assert property ($rose(busy) |-> scl_in && !sda_in) else $error("busy without start");
  stop_seen_a: assert property ($fell(busy) |-> scl_in && sda_in) else $error("idle without stop");
  push_busy_a: assert property ($rose(wr_valid) |-> busy) else $error("push outside transfer");
  ptr_idle_a: assert property (!busy && $past(!busy) |-> $stable(pointer)) else $error("pointer moved idle");
  cover property ($rose(wr_valid));
  cover property ($past(pointer) == 8'h13 && pointer == 8'h00);
  cover property ($rose(sda_oe) && !wr_valid);
endmodule
bind rtc_i2c_register_access rtc_i2c_chk chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy), .pointer(pointer));

// File: verification/i2c_ctl_model.sv
// serial bus controller model: drives scl, pulls sda low
// assumes a pull-up on sda; scl period is 8 ref_clk, idle high
`timescale 1ns/1ps
module i2c_ctl_model (
  // clock
  input wire ref_clk,
  // bus
  input wire sda,
  output reg scl,
  output reg pull
);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task w(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  // data set mid-low, sampled at end of high, well clear of both edges
  task bitx(input b, output r);
    begin
      w(2);
      pull = !b;
      w(2);
      scl = 1'b1;
      w(4);
      r = sda;
      scl = 1'b0;
    end
  endtask
  // start or repeated start: sda falls while scl high
  task start;
    begin
      w(2);
      pull = 1'b0;
      w(2);
      scl = 1'b1;
      w(4);
      pull = 1'b1;
      w(4);
      scl = 1'b0;
    end
  endtask
  task stop;
    begin
      w(2);
      pull = 1'b1;
      w(2);
      scl = 1'b1;
      w(4);
      pull = 1'b0;
      w(8);
    end
  endtask
  task wb(input [7:0] d, output a);
    integer k;
    reg r;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitx(d[k], r);
      bitx(1'b1, r);
      a = !r;
    end
  endtask
  task rb(input ma, output [7:0] d);
    integer k;
    reg r;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitx(1'b1, d[k]);
      bitx(!ma, r);
    end
  endtask
endmodule

// File: verification/rtc_i2c_register_access_tb_top.sv
// bench for the serial register target with a controller model
// assumes ref_clk 100 ns; inputs move on the falling edge
`timescale 1ns/1ps
`include "rtc_i2c_consts.vh"
module rtc_i2c_register_access_tb_top;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg wr_ready = 1'b0;
  reg [7:0] d;
  reg a;
  integer err_total = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer k;
  wire scl, pull, sda_out, sda_oe, wr_valid, busy;
  wire [7:0] wr_addr, wr_data, pointer;
  // wired-and of both parties, pull-up when released
  wire sda = !pull && !(sda_oe && !sda_out);
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  rtc_i2c_register_access dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .busy(busy), .pointer(pointer));
  i2c_ctl_model ctl (.ref_clk(ref_clk), .sda(sda), .scl(scl), .pull(pull));
  task chk(input [7:0] s, input [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e)
      begin
        err_total = err_total + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // byte out, acknowledge compared
  task wid(input [7:0] b, input e);
    begin
      ctl.wb(b, a);
      chk(a, e);
    end
  endtask
  task t_cur;
    begin
      chk(pointer, 8'h00);
      ctl.start;
      wid({`DEV_ID, 1'b1}, 1'b1);
      ctl.rb(1'b0, d);
      chk(d, 8'h00);
      ctl.stop;
      chk(busy, 1'b0);
      $display("t_cur done");
    end
  endtask
  // far side stalls while 17 writes arrive; the last must be refused
  task t_fill;
    begin
      for (k = 0; k < 17; k = k + 1)
      begin
        ctl.start;
        wid({`DEV_ID, 1'b0}, 1'b1);
        wid(8'h04 + k, 1'b1);
        wid(8'h10 + k, k < 16);
        ctl.stop;
        chk(busy, 1'b0);
      end
      for (k = 0; k < 16; k = k + 1)
      begin
        chk(wr_valid, 1'b1);
        chk(wr_addr, 8'h04 + k);
        chk(wr_data, 8'h10 + k);
        wr_ready = 1'b1;
        @(negedge ref_clk);
        wr_ready = 1'b0;
      end
      chk(wr_valid, 1'b0);
      $display("t_fill done");
    end
  endtask
  task t_read;
    begin
      ctl.start;
      wid({`DEV_ID, 1'b0}, 1'b1);
      wid(8'h12, 1'b1);
      ctl.start;
      wid({`DEV_ID, 1'b1}, 1'b1);
      for (k = 0; k < 3; k = k + 1)
      begin
        ctl.rb(k < 2, d);
        chk(d, (k == 0) ? 8'h1E : (k == 1) ? 8'h1F : 8'h00);
      end
      ctl.stop;
      chk(pointer, 8'h01);
      $display("t_read done");
    end
  endtask
  task t_badid;
    begin
      ctl.start;
      wid({`DEV_ID ^ 7'h01, 1'b0}, 1'b0);
      wid(8'h00, 1'b0);
      ctl.stop;
      chk(pointer, 8'h01);
      $display("t_badid done");
    end
  endtask
  // hang guard, about six times the expected run
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_cur;
    t_fill;
    t_read;
    t_badid;
    complete_run;
  end
endmodule
